// file: dv/pwrmc_core_model.sv
// Behavioural model of the processor core and peripherals around the block
`timescale 1ns/10ps
`default_nettype none
module pwrmc_core_model (
  input wire logic sys_clk,          // System clock
  input wire logic resetn,           // Synchronous reset, active low
  input wire logic coreClkEn,        // Core clock enable from the block
  input wire logic sleepCmd,         // Bench asks the core to sleep
  input wire logic irqCmd,           // Bench raises an interrupt
  input wire logic [11:0] wakeCmd,   // Bench raises peripheral wakes
  output logic sleepReq,             // Sleep instruction executed
  output logic irqPending,           // Pending enabled interrupt
  output logic [11:0] wakeSrc        // Peripheral wake requests
);
  // Core only executes a sleep instruction while it is clocked
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sleepReq <= 1'b0;
      irqPending <= 1'b0;
      wakeSrc <= 12'h000;
    end else begin
      sleepReq <= sleepCmd & coreClkEn;
      irqPending <= irqCmd;
      wakeSrc <= wakeCmd;
    end
  end
endmodule // pwrmc_core_model
`default_nettype wire

// file: dv/pwrmc_core_test.sv
// Self-checking testbench of the power mode controller
`timescale 1ns/10ps
`default_nettype none
module pwrmc_core_test;
  import pwrmc_pkg::*;
  logic sys_clk = 1'b0; // System clock
  logic resetn = 1'b0; // Reset, active low
  logic [1:0] runSel = 2'h0; // Run configuration
  logic deepSleepSel = 1'b0; // Stop class select
  logic vlpStopSel = 1'b0; // Very-low stop select
  logic flashBlank = 1'b0; // Blank flash flag
  logic eeWriteReq = 1'b0; // EEPROM write request
  logic flashCmdReq = 1'b0; // Flash command request
  logic sleepCmd = 1'b0; // Model sleep command
  logic irqCmd = 1'b0; // Model interrupt command
  logic [11:0] wakeCmd = 12'h000; // Model wake commands
  logic sleepReq, irqPending, coreClkEn, reducedClk, lvmEnable, nicClkEn;
  logic awcEnable, sramRetain, eeWriteGo, flashCmdGo, flashRefused, wakeDone;
  logic [11:0] wakeSrc, periphClkEn;
  logic [31:0] vectorBase;
  pwrmc_mode_t devMode;
  int nErrors = 0; // Mismatch count
  int nCompared = 0; // Comparison count

  // 50 ns clock
  always #25 sys_clk = ~sys_clk;

  pwrmc_core dut (.sys_clk(sys_clk), .resetn(resetn), .runSel(runSel),
    .deepSleepSel(deepSleepSel), .vlpStopSel(vlpStopSel),
    .sleepReq(sleepReq), .wakeSrc(wakeSrc), .irqPending(irqPending),
    .flashBlank(flashBlank), .eeWriteReq(eeWriteReq),
    .flashCmdReq(flashCmdReq), .devMode(devMode), .coreClkEn(coreClkEn),
    .periphClkEn(periphClkEn), .reducedClk(reducedClk),
    .lvmEnable(lvmEnable), .nicClkEn(nicClkEn), .awcEnable(awcEnable),
    .sramRetain(sramRetain), .eeWriteGo(eeWriteGo), .flashCmdGo(flashCmdGo),
    .flashRefused(flashRefused), .wakeDone(wakeDone),
    .vectorBase(vectorBase));

  pwrmc_core_model core (.sys_clk(sys_clk), .resetn(resetn),
    .coreClkEn(coreClkEn), .sleepCmd(sleepCmd), .irqCmd(irqCmd),
    .wakeCmd(wakeCmd), .sleepReq(sleepReq), .irqPending(irqPending),
    .wakeSrc(wakeSrc));

  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Step to just after the next rising edge
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  // Let the core execute one sleep instruction
  task automatic sleepGo();
    tick();
    sleepCmd = 1'b1;
    tick();
    sleepCmd = 1'b0;
  endtask

  // Wait a bounded time for a mode, then compare it
  task automatic waitMode(input pwrmc_mode_t m);
    for (int i = 0; i < 8 && devMode !== m; i++) begin
      tick();
    end
    chk("devMode", m, devMode);
  endtask

  // Wait a bounded time for the wake pulse, then check the run mode
  task automatic waitWake(input pwrmc_mode_t m);
    for (int i = 0; i < 12 && wakeDone !== 1'b1; i++) begin
      tick();
    end
    chk("wakeDone", 1, wakeDone);
    chk("devMode", m, devMode);
    tick();
    chk("wakeDone", 0, wakeDone);
  endtask

  // Reset values and the flash boot vector
  task automatic testReset();
    chk("devMode", PWRMC_MODE_RUN, devMode);
    chk("coreClkEn", 1, coreClkEn);
    chk("periphClkEn", 12'hFFF, periphClkEn);
    chk("lvmEnable", 1, lvmEnable);
    chk("vectorBase", PWRMC_FLASH_BASE, vectorBase);
    $display("test reset done");
  endtask

  // Run configurations and flash write blocking
  task automatic testRun();
    flashCmdReq = 1'b1;
    eeWriteReq = 1'b1;
    runSel = 2'h1;
    tick();
    tick();
    chk("devMode", PWRMC_MODE_VLPRUN, devMode);
    chk("reducedClk", 1, reducedClk);
    chk("lvmEnable", 0, lvmEnable);
    chk("coreClkEn", 1, coreClkEn);
    chk("periphClkEn", 12'hFFF, periphClkEn);
    chk("flashRefused", 1, flashRefused);
    chk("flashCmdGo", 0, flashCmdGo);
    chk("eeWriteGo", 0, eeWriteGo);
    runSel = 2'h2;
    tick();
    tick();
    chk("devMode", PWRMC_MODE_FASTRUN, devMode);
    chk("flashCmdGo", 0, flashCmdGo);
    chk("eeWriteGo", 0, eeWriteGo);
    runSel = 2'h0;
    tick();
    tick();
    chk("flashCmdGo", 1, flashCmdGo);
    chk("eeWriteGo", 1, eeWriteGo);
    chk("flashRefused", 0, flashRefused);
    flashCmdReq = 1'b0;
    eeWriteReq = 1'b0;
    $display("test run done");
  endtask

  // Wait class entry and interrupt wake
  task automatic testWait(input logic [1:0] rs, input pwrmc_mode_t runM,
                          input pwrmc_mode_t slpM);
    runSel = rs;
    deepSleepSel = 1'b0;
    tick();
    tick();
    sleepGo();
    waitMode(slpM);
    chk("coreClkEn", 0, coreClkEn);
    chk("periphClkEn", 12'hFFF, periphClkEn);
    chk("nicClkEn", 1, nicClkEn);
    chk("reducedClk", rs == 2'h1, reducedClk);
    chk("lvmEnable", rs != 2'h1, lvmEnable);
    irqCmd = 1'b1;
    waitWake(runM);
    irqCmd = 1'b0;
    runSel = 2'h0;
    tick();
    $display("test wait done");
  endtask

  // Stop class entry, ignored and accepted wakes
  task automatic testStop(input logic vlp, input logic [11:0] keep,
                          input int badBit, input int goodBit);
    deepSleepSel = 1'b1;
    vlpStopSel = vlp;
    sleepGo();
    waitMode(vlp ? PWRMC_MODE_VLPSTOP : PWRMC_MODE_STOP);
    chk("periphClkEn", keep, periphClkEn);
    chk("coreClkEn", 0, coreClkEn);
    chk("nicClkEn", 0, nicClkEn);
    chk("awcEnable", 1, awcEnable);
    chk("sramRetain", 1, sramRetain);
    chk("lvmEnable", !vlp, lvmEnable);
    wakeCmd[badBit] = 1'b1;
    repeat (8) tick();
    chk("devMode", vlp ? PWRMC_MODE_VLPSTOP : PWRMC_MODE_STOP, devMode);
    wakeCmd = 12'h001 << goodBit;
    waitWake(PWRMC_MODE_RUN);
    wakeCmd = 12'h000;
    deepSleepSel = 1'b0;
    tick();
    $display("test stop done");
  endtask

  // Second reset with blank flash selects the ROM vector
  task automatic testBoot();
    resetn = 1'b0;
    flashBlank = 1'b1;
    repeat (3) tick();
    resetn = 1'b1;
    tick();
    tick();
    chk("vectorBase", PWRMC_ROM_BASE, vectorBase);
    flashBlank = 1'b0;
    $display("test boot done");
  endtask

  // Print the counts and the verdict, then stop
  task automatic printVerdict();
    $display("compared %0d mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog far beyond the roughly eighty cycles the tests need
  initial begin
    #(2000 * 50);
    nErrors++;
    printVerdict();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    tick();
    testReset();
    testRun();
    testWait(2'h0, PWRMC_MODE_RUN, PWRMC_MODE_WAIT);
    testWait(2'h1, PWRMC_MODE_VLPRUN, PWRMC_MODE_VLPWAIT);
    testStop(1'b0, 12'h01F, 8, 2);
    testStop(1'b1, 12'hFEF, 4, 8);
    testBoot();
    printVerdict();
  end
endmodule // pwrmc_core_test
`default_nettype wire

// file: logic/pwrmc_core.sv
// Power mode controller: mode sequencing, clock gating and write blocking
// Overview of operation
// - Sleep instruction enters wait or stop by configuration
// - All three run modes keep core and peripherals active
// - Wait modes halt core, peripherals keep running
// - Stop modes disable core; stop gates most peripherals, very-low stop only pin interrupts
// - Interrupt controller wakes from wait modes
// - Async wake controller wakes from stop modes
// - Very-low run: reduced clock, voltage monitor off
// - Very-low wait: reduced clock, monitor off, core sleeps
// - Stop gates clocks, retains memory, monitor on
// - Stop keeps converter, comparator, timers, pin interrupts
// - Very-low stop keeps listed peripherals, monitor off
// - High-speed or very-low modes block flash writes
// - Blank device boots from ROM, else flash
// - Interrupt controller handles pending wake after clocks
`timescale 1ns/10ps
`default_nettype none
module pwrmc_core
  import pwrmc_pkg::*;
#(
  parameter int WAKE_CYC = PWRMC_WAKE_CYC
) (
  input wire logic sys_clk,            // System clock, 20 MHz
  input wire logic resetn,             // Synchronous reset, active low
  input wire logic [1:0] runSel,       // Requested run configuration
  input wire logic deepSleepSel,       // Sleep goes to stop class when set
  input wire logic vlpStopSel,         // Stop class uses very-low stop
  input wire logic sleepReq,           // Core executes wait instruction
  input wire logic [11:0] wakeSrc,     // Peripheral wake requests, async
  input wire logic irqPending,         // Enabled interrupt pending
  input wire logic flashBlank,         // Flash is blank, sampled once after reset release
  input wire logic eeWriteReq,         // Emulated EEPROM write request
  input wire logic flashCmdReq,        // Flash command launch request
  output pwrmc_mode_t devMode,         // Current device mode
  output logic coreClkEn,              // Core clock enable
  output logic [11:0] periphClkEn,     // Peripheral clock enables
  output logic reducedClk,             // Reduced frequency required
  output logic lvmEnable,              // Low voltage monitor enable
  output logic nicClkEn,               // Interrupt controller clock on
  output logic awcEnable,              // Async wake controller armed
  output logic sramRetain,             // SRAM retention active
  output logic eeWriteGo,              // Accepted EEPROM write
  output logic flashCmdGo,             // Accepted flash command
  output logic flashRefused,           // Flash or EEPROM request refused
  output logic wakeDone,               // One-cycle pulse on return to run
  output logic [31:0] vectorBase       // Vector table base after reset
);

  typedef enum logic [1:0] {
    PWRMC_ST_RUN,
    PWRMC_ST_SLEEP,
    PWRMC_ST_WAKE
  } pwrmc_state_t;

  // Returns the run mode coding for a run configuration
  function automatic pwrmc_mode_t runMode(input logic [1:0] sel);
    case (sel)
      2'h1: runMode = PWRMC_MODE_VLPRUN;
      2'h2: runMode = PWRMC_MODE_FASTRUN;
      default: runMode = PWRMC_MODE_RUN;
    endcase
  endfunction

  // Wake input synchroniser, two stages
  // Only the second stage feeds logic, so a metastable first stage
  // never reaches the sequencer
  logic [11:0] wakeMeta_q;             // First stage
  logic [11:0] wakeSync_q;             // Second stage
  logic irqMeta_q;                     // Pending interrupt first stage
  logic irqSync_q;                     // Pending interrupt second stage

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wakeMeta_q <= 12'h000;
      wakeSync_q <= 12'h000;
      irqMeta_q <= 1'b0;
      irqSync_q <= 1'b0;
    end else begin
      wakeMeta_q <= wakeSrc;
      wakeSync_q <= wakeMeta_q;
      irqMeta_q <= irqPending;
      irqSync_q <= irqMeta_q;
    end
  end

  // Mode sequencer state
  pwrmc_state_t state_q, state_d;      // Sequencer state
  pwrmc_mode_t mode_q, mode_d;         // Current mode
  pwrmc_mode_t runSave_q, runSave_d;   // Run mode saved over sleep
  logic [3:0] wakeCnt_q, wakeCnt_d;    // Clock restart settle count
  logic wakeDone_q, wakeDone_d;        // Return pulse
  logic [31:0] vector_q, vector_d;     // Boot vector base
  logic bootDone_q, bootDone_d;        // Boot source captured
  logic wakeHit;                       // Wake accepted in this mode
  logic [11:0] keepMask;               // Slots alive in current mode

  // Wake path per mode: interrupt controller or async wake controller
  always_comb begin
    wakeHit = 1'b0;
    case (mode_q)
      PWRMC_MODE_WAIT, PWRMC_MODE_VLPWAIT:
        wakeHit = irqSync_q;
      PWRMC_MODE_STOP:
        wakeHit = |(wakeSync_q & PWRMC_STOP_KEEP);
      PWRMC_MODE_VLPSTOP:
        wakeHit = |(wakeSync_q & PWRMC_VLSTOP_KEEP);
      default: wakeHit = 1'b0;
    endcase
  end

  // Next-state logic for the sequencer
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    runSave_d = runSave_q;
    wakeCnt_d = wakeCnt_q;
    wakeDone_d = 1'b0;
    vector_d = vector_q;
    bootDone_d = 1'b1;
    if (!bootDone_q) begin
      // Capture boot source once after reset release
      vector_d = flashBlank ? PWRMC_ROM_BASE : PWRMC_FLASH_BASE;
    end
    case (state_q)
      PWRMC_ST_RUN: begin
        mode_d = runMode(runSel);
        if (sleepReq) begin
          runSave_d = mode_q;
          state_d = PWRMC_ST_SLEEP;
          if (!deepSleepSel) begin
            mode_d = (mode_q == PWRMC_MODE_VLPRUN) ?
                     PWRMC_MODE_VLPWAIT : PWRMC_MODE_WAIT;
          end else begin
            mode_d = vlpStopSel ? PWRMC_MODE_VLPSTOP : PWRMC_MODE_STOP;
          end
        end
      end
      PWRMC_ST_SLEEP: begin
        if (wakeHit) begin
          state_d = PWRMC_ST_WAKE;
          wakeCnt_d = 4'h0;
        end
      end
      PWRMC_ST_WAKE: begin
        // Clocks restart first, then the pending interrupt is served
        // The sleep mode stays in force until the settle count expires
        wakeCnt_d = wakeCnt_q + 4'h1;
        if (int'(wakeCnt_q) + 1 >= WAKE_CYC) begin
          mode_d = runSave_q;
          state_d = PWRMC_ST_RUN;
          wakeDone_d = 1'b1;
        end
      end
      default: state_d = PWRMC_ST_RUN;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= PWRMC_ST_RUN;
      mode_q <= PWRMC_MODE_RUN;
      runSave_q <= PWRMC_MODE_RUN;
      wakeCnt_q <= 4'h0;
      wakeDone_q <= 1'b0;
      vector_q <= PWRMC_FLASH_BASE;
      bootDone_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      runSave_q <= runSave_d;
      wakeCnt_q <= wakeCnt_d;
      wakeDone_q <= wakeDone_d;
      vector_q <= vector_d;
      bootDone_q <= bootDone_d;
    end
  end

  // Per-mode clock, monitor and retention controls
  always_comb begin
    keepMask = {PWRMC_NPERIPH{1'b1}};
    coreClkEn = 1'b1;
    reducedClk = 1'b0;
    lvmEnable = 1'b1;
    nicClkEn = 1'b1;
    awcEnable = 1'b0;
    sramRetain = 1'b0;
    case (mode_q)
      PWRMC_MODE_RUN, PWRMC_MODE_FASTRUN: begin
        keepMask = {PWRMC_NPERIPH{1'b1}};
      end
      PWRMC_MODE_VLPRUN: begin
        reducedClk = 1'b1;
        lvmEnable = 1'b0;
      end
      PWRMC_MODE_WAIT: begin
        coreClkEn = 1'b0;
      end
      PWRMC_MODE_VLPWAIT: begin
        coreClkEn = 1'b0;
        reducedClk = 1'b1;
        lvmEnable = 1'b0;
      end
      PWRMC_MODE_STOP: begin
        keepMask = PWRMC_STOP_KEEP;
        coreClkEn = 1'b0;
        nicClkEn = 1'b0;
        awcEnable = 1'b1;
        sramRetain = 1'b1;
      end
      PWRMC_MODE_VLPSTOP: begin
        keepMask = PWRMC_VLSTOP_KEEP;
        coreClkEn = 1'b0;
        reducedClk = 1'b1;
        lvmEnable = 1'b0;
        nicClkEn = 1'b0;
        awcEnable = 1'b1;
        sramRetain = 1'b1;
      end
      default: keepMask = {PWRMC_NPERIPH{1'b1}};
    endcase
  end

  // Stop modes keep their wake controller armed until clocks are back
  assign periphClkEn = keepMask;
  assign devMode = mode_q;
  assign wakeDone = wakeDone_q;
  assign vectorBase = vector_q;

  // Flash and emulated EEPROM write blocking
  // Sleep modes refuse too: no core is awake to own a flash command
  logic blockNvm;                                         // Writes blocked
  always_comb begin
    blockNvm = (mode_q != PWRMC_MODE_RUN);
    eeWriteGo = eeWriteReq && !blockNvm;
    flashCmdGo = flashCmdReq && !blockNvm;
    flashRefused = (eeWriteReq || flashCmdReq) && blockNvm;
  end

  // Checks
  stop_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode_q == PWRMC_MODE_STOP) |-> (periphClkEn == PWRMC_STOP_KEEP)
      && lvmEnable && sramRetain && !nicClkEn)
    else $error("stop mode controls wrong");
  nvm_block_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode_q inside {PWRMC_MODE_FASTRUN, PWRMC_MODE_VLPRUN}) && flashCmdReq
      |-> !flashCmdGo && flashRefused)
    else $error("flash command launched in blocked mode");
  sleep_entry_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == PWRMC_ST_RUN) && sleepReq && deepSleepSel |=>
      (mode_q inside {PWRMC_MODE_STOP, PWRMC_MODE_VLPSTOP}))
    else $error("deep sleep did not enter stop");
  wait_core_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode_q inside {PWRMC_MODE_WAIT, PWRMC_MODE_VLPWAIT}) |->
      !coreClkEn && nicClkEn && (periphClkEn == 12'hFFF))
    else $error("wait mode controls wrong");
  vlrun_monitor_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode_q == PWRMC_MODE_VLPRUN) |-> reducedClk && !lvmEnable && coreClkEn)
    else $error("very-low run controls wrong");
  vlstop_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode_q == PWRMC_MODE_VLPSTOP) |-> (periphClkEn == PWRMC_VLSTOP_KEEP)
      && !lvmEnable && awcEnable)
    else $error("very-low stop controls wrong");
  wake_return_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wakeDone |-> (mode_q == $past(runSave_q)) && coreClkEn)
    else $error("wake did not restore run mode");
  wake_bound_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == PWRMC_ST_SLEEP) && wakeHit |-> ##[1:16] wakeDone)
    else $error("wake not completed in time");
  boot_vec_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(bootDone_q) |-> vectorBase ==
      ($past(flashBlank) ? PWRMC_ROM_BASE : PWRMC_FLASH_BASE))
    else $error("boot vector wrong");
  run_full_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode_q inside {PWRMC_MODE_RUN, PWRMC_MODE_FASTRUN}) |-> coreClkEn &&
      (periphClkEn == 12'hFFF) && lvmEnable && !awcEnable)
    else $error("run mode controls wrong");
  vlwait_ctl_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode_q == PWRMC_MODE_VLPWAIT) |->
      reducedClk && !lvmEnable && !coreClkEn)
    else $error("very-low wait controls wrong");
  stop_core_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode_q inside {PWRMC_MODE_STOP, PWRMC_MODE_VLPSTOP}) |->
      !coreClkEn && !nicClkEn && awcEnable && sramRetain)
    else $error("stop class controls wrong");
  ee_block_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode_q inside {PWRMC_MODE_FASTRUN, PWRMC_MODE_VLPRUN}) && eeWriteReq
      |-> !eeWriteGo && flashRefused)
    else $error("EEPROM write accepted in blocked mode");
  sleep_wait_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == PWRMC_ST_RUN) && sleepReq && !deepSleepSel |=>
      (mode_q inside {PWRMC_MODE_WAIT, PWRMC_MODE_VLPWAIT}))
    else $error("sleep did not enter wait");
  wake_entry_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == PWRMC_ST_SLEEP) && wakeHit |=> (state_q == PWRMC_ST_WAKE))
    else $error("accepted wake not followed");
  vector_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    bootDone_q && $past(bootDone_q) |-> $stable(vectorBase))
    else $error("boot vector moved after capture");

endmodule // pwrmc_core
`default_nettype wire

// file: shared/pwrmc_pkg.sv
// Package of modes, peripheral slots and timing for the power mode controller
`default_nettype none
package pwrmc_pkg;
  // Run configuration requested by software-side logic
  typedef enum logic [1:0] {
    PWRMC_RUN_NORMAL,
    PWRMC_RUN_VLP,
    PWRMC_RUN_HIGH_SPEED
  } pwrmc_run_t;

  // Device mode as driven to the chip
  typedef enum logic [2:0] {
    PWRMC_MODE_RUN,
    PWRMC_MODE_VLPRUN,
    PWRMC_MODE_FASTRUN,
    PWRMC_MODE_WAIT,
    PWRMC_MODE_VLPWAIT,
    PWRMC_MODE_STOP,
    PWRMC_MODE_VLPSTOP
  } pwrmc_mode_t;

  // Peripheral clock slot positions
  localparam int PWRMC_NPERIPH = 12;
  localparam int PWRMC_P_CONV = 0;      // Analog converter
  localparam int PWRMC_P_COMPARE = 1;   // Analog comparator
  localparam int PWRMC_P_LPTIMER = 2;   // Low power timer
  localparam int PWRMC_P_RTC = 3;       // Real-time counter
  localparam int PWRMC_P_PINIRQ = 4;    // Pin interrupt logic
  localparam int PWRMC_P_XTAL = 5;      // External oscillator
  localparam int PWRMC_P_PERTIMER = 6;  // Low power periodic timer
  localparam int PWRMC_P_PROGIO = 7;    // Flexible I/O
  localparam int PWRMC_P_UART = 8;      // Low power async serial
  localparam int PWRMC_P_I2C = 9;       // Low power two wire
  localparam int PWRMC_P_SPI = 10;      // Low power sync serial
  localparam int PWRMC_P_DMA = 11;      // DMA engine

  // Slots kept clocked in stop
  localparam logic [11:0] PWRMC_STOP_KEEP = 12'h01F;
  // Slots kept clocked in very-low-power stop, both low power timers too
  localparam logic [11:0] PWRMC_VLSTOP_KEEP = 12'hFEF;
  // Reset value of the run configuration
  localparam logic [1:0] PWRMC_RUN_RST = 2'h0;
  // Boot vector base addresses
  localparam logic [31:0] PWRMC_ROM_BASE = 32'h1C00_0000;
  localparam logic [31:0] PWRMC_FLASH_BASE = 32'h0000_0000;
  // Clocks to hold the sleep state after wake before leaving it
  localparam int PWRMC_WAKE_NS = 100;
  localparam int PWRMC_CLK_NS = 50;
  localparam int PWRMC_WAKE_CYC = (PWRMC_WAKE_NS + PWRMC_CLK_NS - 1) /
                                  PWRMC_CLK_NS;
endpackage : pwrmc_pkg
`default_nettype wire
